/* File: hw/adapter_pkg.sv */
// Package with constants and carrier types for the peripheral adapter host bus block.
package adapter_pkg;
  localparam int          DATA_W       = 8;
  localparam logic [1:0]  PICK_DATA_A  = 2'h0;
  localparam logic [1:0]  PICK_CTRL_A  = 2'h1;
  localparam logic [1:0]  PICK_DATA_B  = 2'h2;
  localparam logic [1:0]  PICK_CTRL_B  = 2'h3;
  localparam int          BIT_EN_EDGE  = 0;
  localparam int          BIT_POL_EDGE = 1;
  localparam int          BIT_ACCESS   = 2;
  localparam int          BIT_EN_CTRL  = 3;
  localparam int          BIT_POL_CTRL = 4;
  localparam int          BIT_OUT_CTRL = 5;
  localparam int          BIT_FLAG_2   = 6;
  localparam int          BIT_FLAG_1   = 7;
  localparam logic [5:0]  CTRL_RESET   = 6'h00;
  localparam logic [7:0]  BYTE_RESET   = 8'h00;

  typedef struct packed {
    logic select_high_first;
    logic select_high_second;
    logic select_low;
    logic reg_pick_high;
    logic reg_pick_low;
    logic read_not_write;
    logic enable;
  } host_bus_t;

  typedef struct packed {
    logic [DATA_W-1:0] dir;
    logic [DATA_W-1:0] out;
    logic [5:0]        ctrl;
  } side_regs_t;
endpackage

/* File: hw/irq_flag_section.sv */
// One section's pair of edge-sensed interrupt flags and its request output.
`timescale 1ns/1ns
module irq_flag_section (
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic [5:0] ctrl_in,
  input  wire logic       e_fall_in,
  input  wire logic       desel_pulse_in,
  input  wire logic       clear_in,
  input  wire logic       edge_line_in,
  input  wire logic       ctrl_line_in,
  output logic      [1:0] flags_out,
  output logic            irq_low_out
);
  import adapter_pkg::*;

  logic [1:0] line;
  logic [1:0] pol;
  logic [1:0] en;
  logic [1:0] prev_q;
  logic [1:0] armed_q;
  logic [1:0] flag_q;
  logic [1:0] hit;
  logic       ctrl_is_input;

  assign line          = {ctrl_line_in, edge_line_in};
  assign pol           = {ctrl_in[BIT_POL_CTRL], ctrl_in[BIT_POL_EDGE]};
  assign en            = {ctrl_in[BIT_EN_CTRL], ctrl_in[BIT_EN_EDGE]};
  assign ctrl_is_input = ~ctrl_in[BIT_OUT_CTRL];
  // Only an active edge seen at an enable strobe counts, on a line used as an input.
  assign hit = armed_q & (line ^ ~pol) & (prev_q ^ pol) & {ctrl_is_input, 1'b1} & {2{e_fall_in}};

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      prev_q  <= 2'h0;
      armed_q <= 2'h0;
      flag_q  <= 2'h0;
    end else begin
      if (e_fall_in) begin
        prev_q <= line;
      end
      if (clear_in) begin
        armed_q <= 2'h0;
      end else if (desel_pulse_in) begin
        armed_q <= 2'h3;
      end
      flag_q <= hit | (flag_q & ~{2{clear_in}});
    end
  end

  assign flags_out   = flag_q;
  assign irq_low_out = |(flag_q & en);
endmodule

/* File: hw/periph_adapter_host_bus_irq.sv */
// Host bus decode, register file and interrupt request outputs of the peripheral adapter.
`timescale 1ns/1ns
// Notes on behaviour
// - Selected only with both high selects high and the low select low.
// - Eight-bit data bus driven only during a selected read.
// - Selected write with read/write low loads the addressed register.
// - Read/write high drives the bus only when addressed and enable high.
// - The enable strobe is the only timing reference for the bus.
// - Active-low reset clears every register bit.
// - Register chosen by the two pick inputs and control bit 2.
// - Two open-drain active-low request outputs, wire-OR capable.
// - Each request output is pulled low by either of two flags.
// - Four enable bits mask each source from its request output.
// - Reading a section's data register clears both its flags.
// - A cleared flag rearms only after an enable pulse while deselected.
// - Edge sensing is conditioned by enable pulses between edges.
// - A rearmed flag sets on the next active input transition.
// - Pick 00 data or direction by bit 2, 01 control; B alike.
// - Control bits 0 to 5 read/write; bits 6 and 7 read-only flags.
// - Flags set only by input edges, never by a host write.
module periph_adapter_host_bus_irq (
  input  wire logic                      clk_in,
  input  wire logic                      rst_n_in,
  input  wire adapter_pkg::host_bus_t    bus_in,
  input  wire logic [adapter_pkg::DATA_W-1:0] data_in,
  output logic [adapter_pkg::DATA_W-1:0] data_out,
  output logic                           data_oe_out,
  input  wire logic [adapter_pkg::DATA_W-1:0] port_a_in,
  input  wire logic [adapter_pkg::DATA_W-1:0] port_b_in,
  input  wire logic                      side_a_edge_input_in,
  input  wire logic                      side_a_control_line_in,
  input  wire logic                      side_b_edge_input_in,
  input  wire logic                      side_b_control_line_in,
  output adapter_pkg::side_regs_t        regs_a_out,
  output adapter_pkg::side_regs_t        regs_b_out,
  output logic                           int_request_side_a_out,
  output logic                           int_request_side_a_oe_out,
  output logic                           int_request_side_b_out,
  output logic                           int_request_side_b_oe_out
);
  import adapter_pkg::*;

  logic             rst_s1_q;
  logic             rst_s2_q;
  logic             e_q;
  logic             e_fall;
  logic             selected;
  logic [1:0]       pick;
  logic             wr_strobe;
  logic             rd_strobe;
  logic             desel_pulse;
  side_regs_t       a_q;
  side_regs_t       b_q;
  logic [1:0]       flags_a;
  logic [1:0]       flags_b;
  logic             irq_a;
  logic             irq_b;
  logic [7:0]       data_a_view;
  logic [7:0]       data_b_view;
  logic [7:0]       read_mux;
  logic [7:0]       data_d;
  logic [7:0]       data_q;
  logic             clear_a;
  logic             clear_b;
  logic             sel_data_a;
  logic             sel_data_b;
  logic             pick_data_a;
  logic             pick_ctrl_a;
  logic             pick_data_b;
  logic             pick_ctrl_b;
  logic             wr_out_a;
  logic             wr_dir_a;
  logic             wr_ctrl_a;
  logic             wr_out_b;
  logic             wr_dir_b;
  logic             wr_ctrl_b;
  logic [7:0]       ctrl_view_a;
  logic [7:0]       ctrl_view_b;
  logic [7:0]       side_view_a;
  logic [7:0]       side_view_b;

  // Reset is applied at once and released only after two clock edges.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end

  assign selected    = bus_in.select_high_first & bus_in.select_high_second & ~bus_in.select_low;
  assign pick        = {bus_in.reg_pick_high, bus_in.reg_pick_low};
  assign e_fall      = e_q & ~bus_in.enable;
  // Selects are sampled at the falling edge and assumed steady over the pulse.
  assign wr_strobe   = e_fall & selected & ~bus_in.read_not_write;
  assign rd_strobe   = e_fall & selected & bus_in.read_not_write;
  assign desel_pulse = e_fall & ~selected;
  assign pick_data_a = (pick == PICK_DATA_A);
  assign pick_ctrl_a = (pick == PICK_CTRL_A);
  assign pick_data_b = (pick == PICK_DATA_B);
  assign pick_ctrl_b = (pick == PICK_CTRL_B);

  assign sel_data_a  = pick_data_a & a_q.ctrl[BIT_ACCESS];
  assign sel_data_b  = pick_data_b & b_q.ctrl[BIT_ACCESS];
  assign clear_a     = rd_strobe & sel_data_a;
  assign clear_b     = rd_strobe & sel_data_b;

  // Each write lands in exactly one register, chosen by the pick inputs and the access bit.
  assign wr_out_a    = wr_strobe & sel_data_a;
  assign wr_dir_a    = wr_strobe & pick_data_a & ~a_q.ctrl[BIT_ACCESS];
  assign wr_ctrl_a   = wr_strobe & pick_ctrl_a;
  assign wr_out_b    = wr_strobe & sel_data_b;
  assign wr_dir_b    = wr_strobe & pick_data_b & ~b_q.ctrl[BIT_ACCESS];
  assign wr_ctrl_b   = wr_strobe & pick_ctrl_b;

  // Data lines driven as outputs read back the output register; inputs read the pins.
  assign data_a_view = (a_q.out & a_q.dir) | (port_a_in & ~a_q.dir);
  assign data_b_view = (b_q.out & b_q.dir) | (port_b_in & ~b_q.dir);
  assign side_view_a = a_q.ctrl[BIT_ACCESS] ? data_a_view : a_q.dir;
  assign side_view_b = b_q.ctrl[BIT_ACCESS] ? data_b_view : b_q.dir;
  // Bit 7 shows the edge input's flag and bit 6 the control line's.
  assign ctrl_view_a = {flags_a[0], flags_a[1], a_q.ctrl};
  assign ctrl_view_b = {flags_b[0], flags_b[1], b_q.ctrl};
  assign read_mux    = pick_ctrl_a ? ctrl_view_a :
                       pick_ctrl_b ? ctrl_view_b :
                       pick_data_a ? side_view_a : side_view_b;
  assign data_d      = read_mux;

  always_ff @(posedge clk_in or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      e_q <= 1'b0;
    end else begin
      e_q <= bus_in.enable;
    end
  end

  always_ff @(posedge clk_in or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      data_q <= BYTE_RESET;
    end else begin
      data_q <= data_d;
    end
  end

  // Side A registers; only bits 0 to 5 of the control word are writable.
  always_ff @(posedge clk_in or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      a_q <= '{dir: BYTE_RESET, out: BYTE_RESET, ctrl: CTRL_RESET};
    end else begin
      if (wr_out_a) begin
        a_q.out <= data_in;
      end
      if (wr_dir_a) begin
        a_q.dir <= data_in;
      end
      if (wr_ctrl_a) begin
        a_q.ctrl <= data_in[5:0];
      end
    end
  end

  // Side B registers, built like side A.
  always_ff @(posedge clk_in or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      b_q <= '{dir: BYTE_RESET, out: BYTE_RESET, ctrl: CTRL_RESET};
    end else begin
      if (wr_out_b) begin
        b_q.out <= data_in;
      end
      if (wr_dir_b) begin
        b_q.dir <= data_in;
      end
      if (wr_ctrl_b) begin
        b_q.ctrl <= data_in[5:0];
      end
    end
  end

  assign data_out    = data_q;
  // The bus is driven from the second clock of a selected read strobe until the strobe falls.
  assign data_oe_out = selected & bus_in.read_not_write & bus_in.enable & e_q;

  irq_flag_section sect_a (
    .clk_in         (clk_in),
    .rst_n_in       (rst_s2_q),
    .ctrl_in        (a_q.ctrl),
    .e_fall_in      (e_fall),
    .desel_pulse_in (desel_pulse),
    .clear_in       (clear_a),
    .edge_line_in   (side_a_edge_input_in),
    .ctrl_line_in   (side_a_control_line_in),
    .flags_out      (flags_a),
    .irq_low_out    (irq_a)
  );

  irq_flag_section sect_b (
    .clk_in         (clk_in),
    .rst_n_in       (rst_s2_q),
    .ctrl_in        (b_q.ctrl),
    .e_fall_in      (e_fall),
    .desel_pulse_in (desel_pulse),
    .clear_in       (clear_b),
    .edge_line_in   (side_b_edge_input_in),
    .ctrl_line_in   (side_b_control_line_in),
    .flags_out      (flags_b),
    .irq_low_out    (irq_b)
  );

  assign regs_a_out = a_q;
  assign regs_b_out = b_q;
  // Open drain: the output value is always low and only the enable pulls the line.
  assign int_request_side_a_out    = 1'b0;
  assign int_request_side_a_oe_out = irq_a;
  assign int_request_side_b_out    = 1'b0;
  assign int_request_side_b_oe_out = irq_b;
endmodule

/* File: verif/periph_adapter_host_bus_irq_asserts.sv */
// Concurrent checks on the host bus port of the peripheral adapter.
`timescale 1ns/1ns
module adapter_checker (
  input wire logic                    clk_in,
  input wire logic                    rst_n_in,
  input wire adapter_pkg::host_bus_t  bus_in,
  input wire logic [7:0]              data_in,
  input wire logic                    data_oe_out,
  input wire adapter_pkg::side_regs_t regs_a_out,
  input wire adapter_pkg::side_regs_t regs_b_out,
  input wire logic                    int_request_side_a_out,
  input wire logic                    int_request_side_a_oe_out,
  input wire logic                    int_request_side_b_out,
  input wire logic                    int_request_side_b_oe_out
);
  import adapter_pkg::*;
  logic      en_q;
  wire       sel  = bus_in.select_high_first & bus_in.select_high_second & ~bus_in.select_low;
  wire       rd   = sel & bus_in.read_not_write & bus_in.enable;
  wire       wr   = sel & ~bus_in.read_not_write & en_q & ~bus_in.enable;
  wire [1:0] pick = {bus_in.reg_pick_high, bus_in.reg_pick_low};
  wire [5:0] d6   = data_in[5:0];
  // Keeps the strobe level of the previous clock to find its falling edge.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      en_q <= 1'b0;
    end else begin
      en_q <= bus_in.enable;
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  AST_OE_ONLY_READ: assert property (data_oe_out |-> rd)
    else $error("data bus driven outside a selected read");
  AST_OE_ON: assert property (rd && $past(rd) |-> data_oe_out)
    else $error("selected read does not drive the bus");
  AST_IRQ_LEVEL: assert property (!int_request_side_a_out && !int_request_side_b_out)
    else $error("request output value is not low");
  AST_DESEL_IGNORED: assert property ($fell(bus_in.enable) && !sel |=>
    $stable(regs_a_out) && $stable(regs_b_out)) else $error("deselected cycle changed a register");
  AST_READ_NO_WRITE: assert property ($fell(bus_in.enable) && rd == 1'b0 && bus_in.read_not_write
    |=> $stable(regs_a_out) && $stable(regs_b_out)) else $error("read changed a register");
  AST_CTRL_A_WRITE: assert property (wr && pick == PICK_CTRL_A |=>
    regs_a_out.ctrl == $past(d6)) else $error("control write not taken at falling strobe");
  AST_PICK_B_WRITE: assert property (wr && pick == PICK_DATA_B |=>
    (regs_b_out.ctrl[BIT_ACCESS] ? regs_b_out.out : regs_b_out.dir) == $past(data_in))
    else $error("side b data or direction write misrouted");
  AST_MASK_A: assert property (int_request_side_a_oe_out |->
    regs_a_out.ctrl[BIT_EN_EDGE] | regs_a_out.ctrl[BIT_EN_CTRL]) else $error("masked source drives request a");
  AST_IRQ_AT_STROBE: assert property ($rose(int_request_side_a_oe_out) |->
    $past(bus_in.enable, 2) && !$past(bus_in.enable)) else $error("request a rose away from a falling strobe");
  cover property ($rose(int_request_side_a_oe_out));
  cover property (data_oe_out);
  cover property ($fell(bus_in.enable) && !sel);
endmodule
bind periph_adapter_host_bus_irq adapter_checker asserts (.clk_in, .rst_n_in, .bus_in, .data_in, .data_oe_out,
  .regs_a_out, .regs_b_out, .int_request_side_a_out, .int_request_side_a_oe_out, .int_request_side_b_out,
  .int_request_side_b_oe_out);

/* File: verif/host_bus_model.sv */
// Host bus master model that runs enable-strobed read and write cycles.
`timescale 1ns/1ns
module host_bus_model (
  input  wire logic              clk_in,
  input  wire logic [7:0]        rd_in,
  input  wire logic              oe_in,
  output adapter_pkg::host_bus_t bus_out,
  output logic [7:0]             data_out
);
  import adapter_pkg::*;
  initial begin
    bus_out = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
    data_out = 8'h00;
  end
  // One strobe of three clocks high and two low; the first select carries the valid-cycle qualifier.
  task automatic cyc(input logic sel, input logic [1:0] pick, input logic rw, input logic [7:0] d,
                     output logic [7:0] q);
    @(negedge clk_in);
    bus_out = '{sel, 1'b1, ~sel, pick[1], pick[0], rw, 1'b1};
    data_out = rw ? ~data_out : d;
    repeat (3) @(negedge clk_in);
    q = oe_in ? rd_in : ~rd_in;
    bus_out.enable = 1'b0;
    repeat (2) @(negedge clk_in);
  endtask
endmodule

/* File: verif/test_periph_adapter_host_bus_irq.sv */
// Self-checking testbench for the peripheral adapter host bus and request logic.
`timescale 1ns/1ns
module test_periph_adapter_host_bus_irq;
  import adapter_pkg::*;
  logic       clk_in = 1'b0, rst_n_in = 1'b0, ea = 1'b0;
  host_bus_t  bus;
  logic [7:0] din, dout, q;
  logic       oe, ia, iaoe, ib, iboe;
  side_regs_t ra, rb;
  int         errors = 0, total_checks = 0;
  always #20 clk_in = ~clk_in;
  host_bus_model host (.clk_in, .rd_in(dout), .oe_in(oe), .bus_out(bus), .data_out(din));
  periph_adapter_host_bus_irq uut (.clk_in, .rst_n_in, .bus_in(bus), .data_in(din), .data_out(dout),
    .data_oe_out(oe), .port_a_in(8'h3c), .port_b_in(8'hc3), .side_a_edge_input_in(ea),
    .side_a_control_line_in(1'b1), .side_b_edge_input_in(1'b0), .side_b_control_line_in(1'b1),
    .regs_a_out(ra), .regs_b_out(rb), .int_request_side_a_out(ia), .int_request_side_a_oe_out(iaoe),
    .int_request_side_b_out(ib), .int_request_side_b_oe_out(iboe));
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [1:0] p, input logic [7:0] d); host.cyc(1'b1, p, 1'b0, d, q); endtask
  task automatic rd(input logic [1:0] p); host.cyc(1'b1, p, 1'b1, 8'h00, q); endtask
  task automatic desel; host.cyc(1'b0, PICK_DATA_A, 1'b1, 8'h00, q); endtask
  task automatic t_reset;
    @(negedge clk_in) rst_n_in = 1'b0;
    repeat (2) @(negedge clk_in);
    chk("reset", 8'h00, {7'h0, |{ra, rb, oe, iaoe, iboe}});
    rst_n_in = 1'b1;
    repeat (4) @(negedge clk_in);
    $display("t_reset done");
  endtask
  task automatic t_regs;
    wr(PICK_CTRL_A, 8'hff);
    chk("ctrl_a", 8'h3f, {2'h0, ra.ctrl});
    rd(PICK_CTRL_A);
    chk("ctrl_a_read", 8'h3f, q);
    chk("oe_after", 8'h00, {7'h0, oe});
    wr(PICK_CTRL_A, 8'h00);
    wr(PICK_DATA_A, 8'h5a);
    chk("dir_a", 8'h5a, ra.dir);
    host.cyc(1'b0, PICK_DATA_A, 1'b0, 8'h11, q);
    chk("dir_a_desel", 8'h5a, ra.dir);
    wr(PICK_CTRL_B, 8'h04);
    wr(PICK_DATA_B, 8'ha5);
    chk("out_b", 8'ha5, rb.out);
    chk("dir_b", 8'h00, rb.dir);
    rd(PICK_DATA_B);
    chk("data_b_read", 8'hc3, q);
    $display("t_regs done");
  endtask
  task automatic t_irq;
    wr(PICK_CTRL_A, 8'h07);
    desel;
    @(negedge clk_in) ea = 1'b1;
    desel;
    chk("irq_a_set", 8'h01, {7'h0, iaoe});
    chk("irq_values", 8'h00, {6'h0, ia, ib});
    chk("irq_b_idle", 8'h00, {7'h0, iboe});
    rd(PICK_CTRL_A);
    chk("flag_read", 8'h87, q);
    wr(PICK_CTRL_A, 8'h06);
    chk("irq_a_mask", 8'h00, {7'h0, iaoe});
    wr(PICK_CTRL_A, 8'h07);
    rd(PICK_DATA_A);
    chk("data_a_read", 8'h24, q);
    chk("irq_a_clear", 8'h00, {7'h0, iaoe});
    @(negedge clk_in) ea = 1'b0;
    rd(PICK_CTRL_A);
    @(negedge clk_in) ea = 1'b1;
    rd(PICK_CTRL_A);
    chk("no_rearm", 8'h00, {7'h0, iaoe});
    desel;
    @(negedge clk_in) ea = 1'b0;
    desel;
    @(negedge clk_in) ea = 1'b1;
    desel;
    chk("irq_a_again", 8'h01, {7'h0, iaoe});
    $display("t_irq done");
  endtask
  initial begin
    t_reset;
    t_regs;
    t_irq;
    t_reset;
    print_verdict;
  end
  initial begin
    #100000;
    errors++;
    print_verdict;
  end
endmodule
